// File: verif/hpp_host_model.sv
// Behavioural 8-bit host processor driving the port; byte_cyc moves one byte, xfer two.
// Assumes the bench calls xfer and byte_cyc one at a time.
module hpp_host_model (
    input wire logic clock,
    input wire logic [7:0] hd_out,
    input wire logic hd_oe,
    input wire logic port_ready,
    output logic port_select_n,
    output logic strobe_a_n,
    output logic strobe_b_n,
    output logic addr_strobe_n,
    output logic reg_sel_lo,
    output logic reg_sel_hi,
    output logic read_not_write,
    output logic second_byte_flag,
    output logic [7:0] hd_in,
    output logic rd_valid,
    output logic [7:0] rd_byte,
    output logic saw_busy
);
    timeunit 1ns;
    timeprecision 1ns;

    initial
    begin
        {port_select_n, strobe_a_n, strobe_b_n, addr_strobe_n} = 4'hF;
        {reg_sel_lo, reg_sel_hi, read_not_write, second_byte_flag} = 4'h0;
        {hd_in, rd_valid, rd_byte, saw_busy} = '0;
    end

    // ------------------------------------------------------------
    // Byte access; both set drives both strobes low together on a write
    // ------------------------------------------------------------
    task automatic byte_cyc(input logic [1:0] sel, input logic rnw,
                            input logic flag, input logic [7:0] d,
                            input logic as, input logic both);
        int n;
        @(posedge clock);
        {reg_sel_hi, reg_sel_lo} <= sel;
        read_not_write <= rnw;
        second_byte_flag <= flag;
        hd_in <= d;
        port_select_n <= 1'b0;
        addr_strobe_n <= !as;
        saw_busy <= 1'b0;
        repeat (5) @(posedge clock);
        if (as)
        begin
            // Latched on the address strobe, so the lines may move now.
            addr_strobe_n <= 1'b1;
            {reg_sel_hi, reg_sel_lo} <= ~sel;
            read_not_write <= !rnw;
            second_byte_flag <= !flag;
        end
        strobe_a_n <= rnw;
        strobe_b_n <= !rnw && !both;
        repeat (8) @(posedge clock);
        rd_byte <= (hd_oe === 1'b1) ? hd_out : 8'hXX;
        rd_valid <= rnw;
        @(posedge clock);
        rd_valid <= 1'b0;
        {strobe_a_n, strobe_b_n} <= 2'h3;
        for (n = 0; n < 14; n++)
        begin
            @(posedge clock);
            if (port_ready !== 1'b1)
                saw_busy <= 1'b1;
            if (n == 6)
                hd_in <= ~d;
        end
        for (n = 0; n < 30 && port_ready !== 1'b1; n++)
            @(posedge clock);
        port_select_n <= 1'b1;
    endtask

    task automatic xfer(input logic [1:0] sel, input logic rnw,
                        input logic [15:0] w, input logic bo, input logic as);
        byte_cyc(sel, rnw, 1'b0, bo ? w[7:0] : w[15:8], as, 1'b0);
        byte_cyc(sel, rnw, 1'b1, bo ? w[15:8] : w[7:0], as, 1'b0);
    endtask
endmodule

// File: verif/hpp_host_port_assertions.sv
// Checker for the host parallel port, bound to every hpp_host_port.
// Sees only the top-level ports; one clock and one synchronous reset.
module hpp_checker (
    input wire logic clock,
    input wire logic rst,
    input wire logic port_select_n,
    input wire logic strobe_a_n,
    input wire logic strobe_b_n,
    input wire logic hd_oe,
    input wire logic port_ready,
    input wire logic host_irq_n,
    input wire hpp_pkg::hpp_core_req_t core_req,
    input wire logic core_irq,
    input wire logic shared_mode
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    // Pin windows allow for the three-flop synchroniser and output flop.
    a_ready_deselect: assert property (port_select_n [*6] |-> port_ready)
        else $error("ready low while deselected");
    a_idle_no_drive: assert property (
        (port_select_n || (strobe_a_n == strobe_b_n)) [*7] |-> !hd_oe)
        else $error("data bus driven without an enabled access");
    a_mode_reset: assert property ($fell(rst) |-> !shared_mode ##1 shared_mode)
        else $error("shared mode wrong around reset");
    a_pins_reset: assert property (
        $fell(rst) |-> host_irq_n && port_ready && !hd_oe)
        else $error("pins wrong at reset release");
    a_core_irq_pulse: assert property (core_irq |=> !core_irq)
        else $error("core interrupt longer than one cycle");
    a_irq_set: assert property (
        core_req.ctl_write && core_req.ctl_wdata[3] |=> !host_irq_n)
        else $error("host interrupt not raised by core");
    a_irq_cause: assert property ($fell(host_irq_n) |->
        $past(core_req.ctl_write) && $past(core_req.ctl_wdata[3]))
        else $error("host interrupt raised without core write");
    a_mode_write: assert property (
        core_req.ctl_write |=> shared_mode == $past(core_req.ctl_wdata[1]))
        else $error("shared mode not taken from core write");
    a_mode_cause: assert property ($changed(shared_mode) |->
        $past(core_req.ctl_write) || $past(rst, 2))
        else $error("shared mode changed without core write");
    a_busy_bounded: assert property ($fell(port_ready) |-> ##[1:8] port_ready)
        else $error("ready held low too long");
endmodule

bind hpp_host_port hpp_checker i_chk (.clock, .rst, .port_select_n,
    .strobe_a_n, .strobe_b_n, .hd_oe, .port_ready, .host_irq_n, .core_req,
    .core_irq, .shared_mode);

// File: verif/hpp_host_port_tb.sv
// Self-checking bench for hpp_host_port with a behavioural host.
// Assumes hpp_pkg, the design, the checker and the host model compiled.
`define CHK(nm, e, g) \
    begin \
        compares++; \
        if ((g) !== (e)) \
        begin \
            $display("unexpected %s exp %h got %h", nm, (e), (g)); \
            fails++; \
        end \
    end

module hpp_host_port_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic addr_strobe_used = 1'b0;
    hpp_pkg::hpp_core_req_t core_req = '0;
    logic port_select_n, strobe_a_n, strobe_b_n, addr_strobe_n;
    logic reg_sel_lo, reg_sel_hi, read_not_write, second_byte_flag;
    logic [7:0] hd_in, hd_out, rd_byte;
    logic hd_oe, port_ready, host_irq_n, core_irq, shared_mode;
    logic rd_valid, saw_busy, bo, as_mode;
    logic [15:0] core_rdata, r, e;
    logic [15:0] q[$];
    int fails = 0;
    int compares = 0;
    int seed = 31160;
    int irq_seen = 0;
    int k;

    always #25 clock = ~clock;

    hpp_host_port i_dut (.clock, .rst, .port_select_n, .strobe_a_n,
        .strobe_b_n, .addr_strobe_n, .addr_strobe_used, .reg_sel_lo,
        .reg_sel_hi, .read_not_write, .second_byte_flag, .hd_in, .hd_out,
        .hd_oe, .port_ready, .host_irq_n, .core_req, .core_rdata, .core_irq,
        .shared_mode);
    hpp_host_model i_host (.clock, .hd_out, .hd_oe, .port_ready,
        .port_select_n, .strobe_a_n, .strobe_b_n, .addr_strobe_n,
        .reg_sel_lo, .reg_sel_hi, .read_not_write, .second_byte_flag, .hd_in,
        .rd_valid, .rd_byte, .saw_busy);

    // ------------------------------------------------------------
    // Result watchers and closing
    // ------------------------------------------------------------
    always @(posedge clock)
    begin
        if (core_irq === 1'b1)
            irq_seen <= irq_seen + 1;
        if (rd_valid === 1'b1)
        begin
            e = (q.size() != 0) ? q.pop_front() : 16'hFFXX;
            `CHK("host byte", e[7:0], rd_byte & e[15:8])
        end
    end

    task automatic close_out();
        if (fails == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (8000) @(posedge clock);
        fails++;
        close_out();
    end

    // ------------------------------------------------------------
    // Host and core helpers
    // ------------------------------------------------------------
    task automatic hw(input logic [1:0] s, input logic [15:0] w);
        i_host.xfer(s, 1'b0, w, bo, as_mode);
    endtask

    task automatic hr(input logic [1:0] s, input logic [15:0] w,
                      input logic [7:0] m);
        q.push_back({m, bo ? w[7:0] : w[15:8]});
        q.push_back({m, bo ? w[15:8] : w[7:0]});
        i_host.xfer(s, 1'b1, 16'h0000, bo, as_mode);
    endtask

    task automatic ctl(input logic [3:0] b);
        i_host.xfer(hpp_pkg::SEL_CONTROL, 1'b0, {2{4'h0, b}}, bo, 1'b0);
        bo = b[hpp_pkg::BIT_BYTE_ORDER];
    endtask

    // Holds the request three cycles, then compares read data if asked.
    task automatic core_op(input hpp_pkg::hpp_core_req_t c, input logic chk,
                           input logic [15:0] x);
        @(posedge clock);
        core_req <= c;
        repeat (3) @(posedge clock);
        if (chk)
            `CHK("core read", x, core_rdata)
        core_req <= '0;
        @(posedge clock);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        bo = 1'b1;
        as_mode = 1'b0;
        repeat (16) @(posedge clock);
        `CHK("reset pins", 4'hC, {port_ready, host_irq_n, shared_mode, hd_oe})
        rst <= 1'b0;
        repeat (6) @(posedge clock);
        `CHK("mode", 1'b1, shared_mode)
        ctl(4'h1);
        hr(hpp_pkg::SEL_CONTROL, 16'h0303, 8'h0F);
        hw(hpp_pkg::SEL_POINTER, 16'h07FF);
        `CHK("busy", 1'b1, saw_busy)
        hr(hpp_pkg::SEL_POINTER, 16'h07FF, 8'hFF);
        r = 16'($random(seed));
        hw(hpp_pkg::SEL_DATA_INC, r);
        hr(hpp_pkg::SEL_POINTER, 16'h0800, 8'hFF);
        hw(hpp_pkg::SEL_POINTER, 16'h1800);
        hr(hpp_pkg::SEL_DATA, r, 8'hFF);
        hr(hpp_pkg::SEL_POINTER, 16'h1800, 8'hFF);
        r = 16'($random(seed));
        hw(hpp_pkg::SEL_POINTER, 16'hFFFF);
        hw(hpp_pkg::SEL_DATA_INC, r);
        hr(hpp_pkg::SEL_POINTER, 16'h0000, 8'hFF);
        hr(hpp_pkg::SEL_DATA_INC, r, 8'hFF);
        hr(hpp_pkg::SEL_POINTER, 16'h0001, 8'hFF);
        ctl(4'h0);
        hr(hpp_pkg::SEL_POINTER, 16'h0001, 8'hFF);
        r = 16'($random(seed));
        core_op('{1'b1, 1'b1, 1'b0, hpp_pkg::DATA_BASE + 16'h0006, r,
                  4'h0, 1'b0}, 1'b0, r);
        core_op('{1'b0, 1'b0, 1'b0, 16'h0000, 16'h0000, 4'hA, 1'b1},
                1'b0, r);
        `CHK("irq pin", 1'b0, host_irq_n)
        hr(hpp_pkg::SEL_CONTROL, 16'h0A0A, 8'h0F);
        ctl(4'h8);
        `CHK("irq pin", 1'b1, host_irq_n)
        k = irq_seen;
        ctl(4'h4);
        `CHK("core irq", k + 1, irq_seen)
        hr(hpp_pkg::SEL_CONTROL, 16'h0202, 8'h0F);
        i_host.byte_cyc(hpp_pkg::SEL_CONTROL, 1'b0, 1'b0, 8'h04, 1'b0, 1'b1);
        i_host.byte_cyc(hpp_pkg::SEL_CONTROL, 1'b0, 1'b1, 8'h04, 1'b0, 1'b1);
        `CHK("core irq", k + 1, irq_seen)
        core_op('{1'b0, 1'b0, 1'b0, 16'h0000, 16'h0000, 4'h0, 1'b1},
                1'b0, r);
        `CHK("mode", 1'b0, shared_mode)
        core_op('{1'b1, 1'b1, 1'b0, hpp_pkg::DATA_BASE + 16'h0006, ~r,
                  4'h0, 1'b0}, 1'b0, r);
        core_op('{1'b0, 1'b0, 1'b0, 16'h0000, 16'h0000, 4'h2, 1'b1},
                1'b0, r);
        hw(hpp_pkg::SEL_POINTER, 16'h0006);
        hr(hpp_pkg::SEL_DATA, r, 8'hFF);
        core_op('{1'b1, 1'b0, 1'b1, hpp_pkg::PROG_BASE + 16'h0006, 16'h0000,
                  4'h0, 1'b0}, 1'b1, r);
        addr_strobe_used <= 1'b1;
        as_mode = 1'b1;
        hw(hpp_pkg::SEL_POINTER, 16'h0ABC);
        hr(hpp_pkg::SEL_POINTER, 16'h0ABC, 8'hFF);
        repeat (5) @(posedge clock);
        `CHK("notes left", 0, q.size())
        close_out();
    end
endmodule

// File: verilog/hpp_host_port.sv
// Host parallel port: 8-bit host bus into a 2K x 16 RAM shared with a core.
// Host select and strobes are asynchronous and pass three flops; the core side runs on
// the same clock as this block.

// What this block does
// - Sampling strobe is chip select plus data strobe, whichever comes last.
// - The two data strobes combine by XNOR; both low is not an access.
// - Ready output is held high whenever chip select is high.
// - With address strobe used, its falling edge latches the controls.
// - Select 00 routes host reads and writes to the control register.
// - Select 01 reaches data latches; pointer post-read, pre-write increment.
// - Select 10 routes host reads and writes to the memory pointer.
// - Select 11 reaches data latches and leaves the pointer unchanged.
// - Host RAM address is the low 11 pointer bits; higher bits alias.
// - Pointer is 16 bits readable and writable; increment carries through all.
// - Core sees RAM at 1000h-17FFh data or 8800h-8FFFh program space.
// - Shared mode: 1 shared, 0 host-only; core-written, 0 in reset.
// - Byte order 1 means first byte low; host-only, hidden from core.
// - Host writing 1 to core interrupt bit pulses it; reads 0.
// - Host interrupt: core sets, host clears with 1; reads 1 while pin low.
// - Ready is low while the internal transfer finishes, high when free.
// - Control bits sit in the four low bits, mirrored in each host byte.
module hpp_host_port (
    input wire logic clock,
    input wire logic rst,
    input wire logic port_select_n,
    input wire logic strobe_a_n,
    input wire logic strobe_b_n,
    input wire logic addr_strobe_n,
    input wire logic addr_strobe_used,
    input wire logic reg_sel_lo,
    input wire logic reg_sel_hi,
    input wire logic read_not_write,
    input wire logic second_byte_flag,
    input wire logic [7:0] hd_in,
    output logic [7:0] hd_out,
    output logic hd_oe,
    output logic port_ready,
    output logic host_irq_n,
    input wire hpp_pkg::hpp_core_req_t core_req,
    output logic [15:0] core_rdata,
    output logic core_irq,
    output logic shared_mode
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [15:0] ram [hpp_pkg::RAM_WORDS];
    hpp_pkg::hpp_regs_t r;
    hpp_pkg::hpp_regs_t next_r;
    logic rst_seen;
    // Host write data is registered every cycle and taken after the strobe has gone inactive.
    logic [7:0] hd_bus;
    logic [hpp_pkg::RAM_AW-1:0] core_index;
    logic core_hit;
    logic core_we;

    // Core window decode; host-only mode blocks every core RAM access.
    always_comb
    begin
        core_index = core_req.addr[hpp_pkg::RAM_AW-1:0];
        if (core_req.program_space)
        begin
            core_hit = core_req.addr >= hpp_pkg::PROG_BASE
                && core_req.addr <= hpp_pkg::PROG_LAST;
        end
        else
        begin
            core_hit = core_req.addr >= hpp_pkg::DATA_BASE
                && core_req.addr <= hpp_pkg::DATA_LAST;
        end
        core_hit = core_hit && core_req.select && r.shared_mode;
        core_we = core_hit && core_req.write && !r.ram_we;
    end

    // ------------------------------------------------------------
    // RAM port: host transfers take priority over the core write.
    // ------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (r.ram_we)
        begin
            ram[r.pointer[hpp_pkg::RAM_AW-1:0]] <= r.write_latch;
        end
        else if (core_we)
        begin
            ram[core_index] <= core_req.wdata;
        end
    end

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        logic enable_now;
        logic enable_prev;
        logic as_now;
        logic as_prev;
        logic [7:0] ctl_byte;
        logic [15:0] word;
        hpp_pkg::hpp_ctl_t c;
        logic first_low;
        hpp_pkg::hpp_ctl_t cap;
        enable_now = 1'b0;
        enable_prev = 1'b0;
        as_now = 1'b0;
        as_prev = 1'b0;
        ctl_byte = 8'h00;
        word = 16'h0000;
        c = '0;
        first_low = 1'b0;
        cap = '0;
        next_r = r;

        // Three-stage synchronisers for select and strobes, two-stage for controls; decisions use stages 1 and 2 only.
        next_r.port_select_n_s = {r.port_select_n_s[1:0], port_select_n};
        next_r.strobe_a_n_s = {r.strobe_a_n_s[1:0], strobe_a_n};
        next_r.strobe_b_n_s = {r.strobe_b_n_s[1:0], strobe_b_n};
        next_r.addr_strobe_n_s = {r.addr_strobe_n_s[1:0], addr_strobe_n};
        next_r.sel_s = {r.sel_s[1:0], reg_sel_hi, reg_sel_lo};
        next_r.rnw_s = {r.rnw_s[1:0], read_not_write, 1'b0};
        next_r.sbf_s = {r.sbf_s[1:0], second_byte_flag, 1'b0};

        // Strobe XNOR then gated by chip select; last arrival wins.
        enable_now = !r.port_select_n_s[1]
            && !(r.strobe_a_n_s[1] ~^ r.strobe_b_n_s[1]);
        enable_prev = !r.port_select_n_s[2]
            && !(r.strobe_a_n_s[2] ~^ r.strobe_b_n_s[2]);
        as_now = !r.addr_strobe_n_s[1];
        as_prev = !r.addr_strobe_n_s[2];

        cap.reg_sel = r.sel_s[3:2];
        cap.read_not_write = r.rnw_s[3];
        cap.second_byte_flag = r.sbf_s[3];
        // Address strobe lets the host drop controls early.
        if (addr_strobe_used && as_now && !as_prev)
        begin
            next_r.ctl = cap;
        end

        ctl_byte = {4'h0, r.host_irq_flag, 1'b0, r.shared_mode,
            r.byte_order};
        first_low = r.byte_order;
        next_r.core_irq_request = 1'b0;
        next_r.ram_we = 1'b0;
        next_r.ram_re = r.ram_re;
        // Prefetch reads the pointer as it now stands, so that a pointer
        // just loaded or incremented is the one that is fetched.
        if (r.ram_re)
        begin
            next_r.read_latch = ram[r.pointer[hpp_pkg::RAM_AW-1:0]];
            next_r.ram_re = 1'b0;
        end

        unique case (r.state)
            hpp_pkg::ST_IDLE:
            begin
                if (enable_now && !enable_prev)
                begin
                    c = addr_strobe_used ? r.ctl : cap;
                    next_r.ctl = c;
                    next_r.state = hpp_pkg::ST_ACCESS;
                    next_r.hd_oe = c.read_not_write;
                    if (c.reg_sel == hpp_pkg::SEL_CONTROL)
                    begin
                        next_r.hd_out = ctl_byte;
                    end
                    else
                    begin
                        word = (c.reg_sel == hpp_pkg::SEL_POINTER)
                            ? r.pointer : r.read_latch;
                        next_r.hd_out = (first_low ^ c.second_byte_flag)
                            ? word[7:0] : word[15:8];
                    end
                end
            end
            hpp_pkg::ST_ACCESS:
            begin
                if (!enable_now)
                begin
                    next_r.hd_oe = 1'b0;
                    next_r.state = hpp_pkg::ST_IDLE;
                    if (!r.ctl.read_not_write && !r.ctl.second_byte_flag)
                    begin
                        next_r.first_byte = hd_bus;
                    end
                    if (r.ctl.second_byte_flag)
                    begin
                        word = first_low ? {hd_bus, r.first_byte}
                            : {r.first_byte, hd_bus};
                        if (r.ctl.read_not_write)
                        begin
                            if (r.ctl.reg_sel == hpp_pkg::SEL_DATA_INC)
                            begin
                                next_r.pointer = r.pointer + 16'h0001;
                                next_r.state = hpp_pkg::ST_BUSY;
                                next_r.ram_re = 1'b1;
                            end
                        end
                        else
                        begin
                            unique case (r.ctl.reg_sel)
                                hpp_pkg::SEL_CONTROL:
                                begin
                                    next_r.byte_order =
                                        word[hpp_pkg::BIT_BYTE_ORDER];
                                    next_r.core_irq_request =
                                        word[hpp_pkg::BIT_CORE_IRQ];
                                    if (word[hpp_pkg::BIT_HOST_IRQ])
                                    begin
                                        next_r.host_irq_flag = 1'b0;
                                    end
                                end
                                hpp_pkg::SEL_POINTER:
                                begin
                                    next_r.pointer = word;
                                    next_r.state = hpp_pkg::ST_BUSY;
                                    next_r.ram_re = 1'b1;
                                end
                                hpp_pkg::SEL_DATA_INC:
                                begin
                                    next_r.pointer = r.pointer + 16'h0001;
                                    next_r.write_latch = word;
                                    next_r.read_latch = word;
                                    next_r.state = hpp_pkg::ST_BUSY;
                                end
                                hpp_pkg::SEL_DATA:
                                begin
                                    next_r.write_latch = word;
                                    next_r.read_latch = word;
                                    next_r.state = hpp_pkg::ST_BUSY;
                                end
                            endcase
                            if (r.ctl.reg_sel[0])
                            begin
                                next_r.ram_we = 1'b1;
                            end
                        end
                        next_r.busy_cnt = hpp_pkg::BUSY_COUNT;
                    end
                end
            end
            hpp_pkg::ST_BUSY:
            begin
                // Read-ahead follows a pointer write or an incrementing read, not a data write.
                if (r.busy_cnt == 4'h1)
                begin
                    next_r.state = hpp_pkg::ST_IDLE;
                end
                next_r.busy_cnt = r.busy_cnt - 4'h1;
            end
            default:
            begin
                next_r.state = hpp_pkg::ST_IDLE;
            end
        endcase

        // Core control writes: shared mode and host interrupt set.
        if (core_req.ctl_write)
        begin
            next_r.shared_mode = core_req.ctl_wdata[hpp_pkg::BIT_SHARED_MODE];
            if (core_req.ctl_wdata[hpp_pkg::BIT_HOST_IRQ])
            begin
                next_r.host_irq_flag = 1'b1;
            end
        end
        next_r.host_irq_n = !next_r.host_irq_flag;

        // Core reads: byte order and the core interrupt bit read as zero.
        next_r.core_rdata = core_hit ? ram[core_index]
            : {12'h000, r.host_irq_flag, 1'b0, r.shared_mode, 1'b0};

        // Ready drops while busy; chip select high forces it high.
        next_r.port_ready = next_r.port_select_n_s[2]
            || (next_r.state != hpp_pkg::ST_BUSY);
        if (rst)
        begin
            next_r = '0;
            next_r.state = hpp_pkg::ST_IDLE;
            next_r.port_select_n_s = 3'h7;
            next_r.strobe_a_n_s = 3'h7;
            next_r.strobe_b_n_s = 3'h7;
            next_r.addr_strobe_n_s = 3'h7;
            next_r.pointer = hpp_pkg::POINTER_RESET;
            next_r.read_latch = hpp_pkg::LATCH_RESET;
            next_r.shared_mode = 1'b0;
            next_r.port_ready = 1'b1;
            next_r.host_irq_n = 1'b1;
        end
        else if (rst_seen == 1'b0)
        begin
            next_r.shared_mode = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Reset release marker and state register
    // ------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        hd_bus <= hd_in;
        rst_seen <= rst ? 1'b0 : 1'b1;
        r <= next_r;
    end

    assign hd_out = r.hd_out;
    assign hd_oe = r.hd_oe;
    assign port_ready = r.port_ready;
    assign host_irq_n = r.host_irq_n;
    assign core_rdata = r.core_rdata;
    assign core_irq = r.core_irq_request;
    assign shared_mode = r.shared_mode;

endmodule

// File: verilog/hpp_pkg.sv
// Package for the host parallel port with its shared word RAM.
// Assumes one 20 MHz clock and a synchronous active-high reset.
package hpp_pkg;

    // ------------------------------------------------------------
    // Geometry and encodings
    // ------------------------------------------------------------
    localparam int RAM_WORDS = 2048;
    localparam int RAM_AW = 11;
    localparam logic [1:0] SEL_CONTROL = 2'h0;
    localparam logic [1:0] SEL_DATA_INC = 2'h1;
    localparam logic [1:0] SEL_POINTER = 2'h2;
    localparam logic [1:0] SEL_DATA = 2'h3;

    // Control register bit positions, mirrored in both host bytes.
    localparam int BIT_BYTE_ORDER = 0;
    localparam int BIT_SHARED_MODE = 1;
    localparam int BIT_CORE_IRQ = 2;
    localparam int BIT_HOST_IRQ = 3;

    // Core address windows for the shared RAM.
    localparam logic [15:0] DATA_BASE = 16'h1000;
    localparam logic [15:0] DATA_LAST = 16'h17FF;
    localparam logic [15:0] PROG_BASE = 16'h8800;
    localparam logic [15:0] PROG_LAST = 16'h8FFF;

    // Reset values.
    localparam logic [15:0] POINTER_RESET = 16'h0000;
    localparam logic [15:0] LATCH_RESET = 16'h0000;

    // Busy time after a data write, pointer write or incrementing data read, about five core cycles.
    localparam int BUSY_NS = 250;
    localparam int CLOCK_NS = 50;
    localparam int BUSY_CYCLES = (BUSY_NS + CLOCK_NS - 1) / CLOCK_NS;
    localparam logic [3:0] BUSY_COUNT = 4'(BUSY_CYCLES);

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ACCESS = 3'b010,
        ST_BUSY = 3'b100
    } hpp_state_t;

    typedef struct packed {
        logic [1:0] reg_sel;
        logic read_not_write;
        logic second_byte_flag;
    } hpp_ctl_t;

    typedef struct packed {
        logic select;
        logic write;
        logic program_space;
        logic [15:0] addr;
        logic [15:0] wdata;
        logic [3:0] ctl_wdata;
        logic ctl_write;
    } hpp_core_req_t;

    typedef struct packed {
        hpp_state_t state;
        logic [2:0] port_select_n_s;
        logic [2:0] strobe_a_n_s;
        logic [2:0] strobe_b_n_s;
        logic [2:0] addr_strobe_n_s;
        logic [3:0] sel_s;
        logic [3:0] rnw_s;
        logic [3:0] sbf_s;
        hpp_ctl_t ctl;
        logic [7:0] first_byte;
        logic [15:0] pointer;
        logic [15:0] read_latch;
        logic [15:0] write_latch;
        logic byte_order;
        logic shared_mode;
        logic host_irq_flag;
        logic core_irq_request;
        logic [3:0] busy_cnt;
        logic ram_we;
        logic ram_re;
        logic [7:0] hd_out;
        logic hd_oe;
        logic port_ready;
        logic host_irq_n;
        logic [15:0] core_rdata;
    } hpp_regs_t;

endpackage
